/* atp_pkg.sv */
// constants, command kinds and decode shared by both ends of the port link
// assumes a 250 MHz core clock; the link clock is derived by the device end
package atp_pkg;
	// register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_COMMAND = 8'h04;
	localparam logic [7:0] REG_CONTROL = 8'h08;
	localparam logic [7:0] REG_ACCEPT_CNT = 8'h0c;
	localparam logic [7:0] REG_REJECT_CNT = 8'h10;
	localparam logic [7:0] REG_SNOOP_CNT = 8'h14;
	localparam logic [7:0] REG_FW_DATA = 8'h18;
	localparam logic [7:0] REG_BYTES = 8'h1c;
	// field positions
	localparam int STAT_MODE30_BIT = 3;
	localparam int STAT_LOCK_BIT = 4;
	localparam int CMD_FW_EN_BIT = 4;
	localparam int CMD_PORT_EN_BIT = 5;
	localparam int CTL_PCI66_BIT = 0;
	localparam int CTL_LAT_LSB = 4;
	// reset values and rate capabilities
	localparam logic [7:0] COMMAND_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [2:0] RATE_CAP_20 = 3'h5; // 1X and 4X, no 2X
	localparam logic [2:0] RATE_CAP_30 = 3'h3; // 4X and 8X
	// bytes per link clock at each rate, and throttle block length
	localparam logic [5:0] BYTES_1X = 6'h04;
	localparam logic [5:0] BYTES_4X = 6'h10;
	localparam logic [5:0] BYTES_8X = 6'h20;
	localparam int BLOCK_CLOCKS = 4;
	// data latency limits in link clocks
	localparam logic [4:0] LAT_LIMIT_STD = 5'h08;
	localparam logic [4:0] LAT_LIMIT_PCI66 = 5'h10;
	// link clock timing: core period and link half period
	localparam int CORE_PERIOD_NS = 4;
	localparam int LINK_HALF_NS = 8;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + CORE_PERIOD_NS - 1)
		/ CORE_PERIOD_NS;
	// delivery path of a request
	localparam logic [1:0] PATH_PIPE = 2'h0;
	localparam logic [1:0] PATH_SBA = 2'h1;
	localparam logic [1:0] PATH_FRAME = 2'h2;

	typedef enum logic [2:0] {
		K_READ, K_WRITE, K_FLUSH, K_FENCE, K_RSVD
	} atp_kind_t;

	// command decode per signalling mode
	function automatic atp_kind_t atp_decode(input logic mode30,
		input logic [3:0] code);
		atp_kind_t k;
		k = K_RSVD;
		case (code)
			4'h0: k = K_READ;
			4'h1: k = mode30 ? K_RSVD : K_READ;
			4'h4: k = K_WRITE;
			4'h5: k = mode30 ? K_RSVD : K_WRITE;
			4'h8, 4'h9: k = mode30 ? K_RSVD : K_READ;
			4'ha: k = K_FLUSH;
			4'hc: k = K_FENCE;
			default: k = K_RSVD; // 1101 and the rest
		endcase
		return k;
	endfunction

	// isoch and align codes that the card must not send in 3.0
	function automatic logic atp_unsupported30(input logic [3:0] code);
		return code == 4'h3 || code == 4'h6 || code == 4'h7 ||
			code == 4'he;
	endfunction
endpackage

/* atp_link_if.sv */
// link wires between the device end and the graphics card end
// assumes both ends sit on the same core clock in the bench
`timescale 1ns/1ns
interface atp_link_if;
	logic link_clk;
	logic req_pin;
	logic [1:0] path;
	logic [3:0] cmd_pin;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic ack_pin;
	logic ok;
	logic [31:0] rdata;
	logic fw_tgl;
	logic [31:0] fw_data;

	modport dev (output link_clk, output ack_pin, output ok,
		output rdata, output fw_tgl, output fw_data,
		input req_pin, input path, input cmd_pin, input addr,
		input wdata);
	modport card (input link_clk, input ack_pin, input ok,
		input rdata, input fw_tgl, input fw_data,
		output req_pin, output path, output cmd_pin, output addr,
		output wdata);
endinterface

/* atp_card.sv */
// graphics card end: sends one request at a time, takes fast writes
// assumes link inputs are asynchronous and the device makes link_clk
`timescale 1ns/1ns
module atp_card import atp_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic mode30_strap,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [3:0] cmd_code,
	input wire logic [1:0] cmd_path,
	input wire logic [31:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	output logic resp_valid,
	output logic resp_ok,
	output logic [31:0] resp_rdata,
	output logic fw_valid,
	output logic [31:0] fw_rdata,
	atp_link_if.card link
);
	localparam int SW = 68;
	typedef enum {C_IDLE, C_REQ, C_ACK, C_DROP} atp_cstate_t;

	logic [SW-1:0] s1_r;
	logic [SW-1:0] s2_r;
	logic lclk_d_r;
	logic fw_d_r;
	logic m30_1_r;
	logic m30_r;
	atp_cstate_t st_r;
	logic [3:0] code_r;
	logic lrise;
	logic ack;

	// every link input passes two flops before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			m30_1_r <= 1'b0;
			m30_r <= 1'b0;
		end else begin
			s1_r <= {link.link_clk, link.ack_pin, link.ok, link.rdata,
				link.fw_tgl, link.fw_data};
			s2_r <= s1_r;
			m30_1_r <= mode30_strap;
			m30_r <= m30_1_r;
		end
	end

	assign lrise = s2_r[67] & ~lclk_d_r;
	assign ack = m30_r ? s2_r[66] : ~s2_r[66];

	// request handshake, one outstanding at a time; sole agent
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= C_IDLE;
			lclk_d_r <= 1'b0;
			cmd_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_ok <= 1'b0;
			resp_rdata <= '0;
			code_r <= '0;
			link.req_pin <= 1'b1; // 2.0 idle level until mode known, the request level in 3.0
			link.path <= PATH_PIPE;
			link.cmd_pin <= '0;
			link.addr <= '0;
			link.wdata <= '0;
		end else begin
			lclk_d_r <= s2_r[67];
			resp_valid <= 1'b0;
			case (st_r)
				C_IDLE: begin
					link.req_pin <= ~m30_r;
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						if (m30_r && atp_unsupported30(cmd_code)) begin
							resp_valid <= 1'b1; // refused locally
							resp_ok <= 1'b0;
						end else begin
							code_r <= cmd_code;
							link.path <= cmd_path;
							link.addr <= cmd_addr;
							link.wdata <= cmd_wdata;
							st_r <= C_REQ;
						end
					end
				end
				C_REQ: if (lrise) begin
					link.req_pin <= m30_r;
					link.cmd_pin <= m30_r ? ~code_r : code_r;
					st_r <= C_ACK;
				end
				C_ACK: if (lrise && ack) begin
					resp_ok <= s2_r[65];
					resp_rdata <= s2_r[64:33];
					link.req_pin <= ~m30_r;
					st_r <= C_DROP;
				end
				C_DROP: if (!ack) begin
					resp_valid <= 1'b1;
					st_r <= C_IDLE;
				end
				default: st_r <= C_IDLE;
			endcase
		end
	end

	// fast write arrives as a toggle with its word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fw_d_r <= 1'b0;
			fw_valid <= 1'b0;
			fw_rdata <= '0;
		end else begin
			fw_d_r <= s2_r[32];
			fw_valid <= s2_r[32] ^ fw_d_r;
			if (s2_r[32] ^ fw_d_r)
				fw_rdata <= s2_r[31:0];
		end
	end
endmodule

/* atp_dev.sv */
// device end: graphics-port target with an axi4-lite register slave
// assumes card pins are asynchronous; link_clk is made here by a divider
`timescale 1ns/1ns
module atp_dev import atp_pkg::*; #(
	parameter int MEM_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_good,
	input wire logic mode30_detect,
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic wbuf_snoop,
	output logic proc_snoop,
	atp_link_if.dev link
);
	localparam int SW = 71;
	localparam int AW = $clog2(MEM_DEPTH);
	typedef enum {D_IDLE, D_WAIT, D_HOLD} atp_dstate_t;

	logic [SW-1:0] s1_r;
	logic [SW-1:0] s2_r;
	logic [1:0] pg_r;
	logic [1:0] det_r;
	logic pg_d_r;
	logic mode30_r;
	logic [7:0] command_r;
	logic [7:0] control_r;
	logic lock_r;
	logic [31:0] acc_cnt_r;
	logic [31:0] rej_cnt_r;
	logic [31:0] snoop_cnt_r;
	logic [31:0] bytes_r;
	logic [31:0] mem_r [MEM_DEPTH];
	atp_dstate_t st_r;
	logic [4:0] lat_r;
	logic is_wr_r;
	logic [$clog2(LINK_HALF_CYC+1)-1:0] div_r;
	logic lfall;
	logic aw_h_r;
	logic w_h_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdat_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic req;
	logic [3:0] code;
	logic [1:0] path;
	logic [AW-1:0] widx;
	atp_kind_t kind;
	logic pci66;
	logic [4:0] lat_need;
	logic [4:0] lat_lim;
	logic [5:0] bpc;
	logic [31:0] status;

	// card pins and straps pass two flops before any logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			pg_r <= '0;
			det_r <= '0;
		end else begin
			s1_r <= {link.req_pin, link.path, link.cmd_pin, link.addr,
				link.wdata};
			s2_r <= s1_r;
			pg_r <= {pg_r[0], power_good};
			det_r <= {det_r[0], mode30_detect};
		end
	end

	// mode strap caught on the rising edge of power good
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pg_d_r <= 1'b0;
			mode30_r <= 1'b0;
		end else begin
			pg_d_r <= pg_r[1];
			if (pg_r[1] && !pg_d_r)
				mode30_r <= det_r[1];
		end
	end

	// polarity follows the mode; command pins are inverted in 3.0
	assign req = mode30_r ? s2_r[70] : ~s2_r[70];
	assign code = mode30_r ? ~s2_r[67:64] : s2_r[67:64];
	assign path = s2_r[69:68];
	assign widx = s2_r[32+AW-1:32];
	assign kind = atp_decode(mode30_r, code);
	assign pci66 = control_r[CTL_PCI66_BIT];
	assign lat_need = {1'b0, control_r[CTL_LAT_LSB+3:CTL_LAT_LSB]};
	assign lat_lim = pci66 ? LAT_LIMIT_PCI66 : LAT_LIMIT_STD;

	// rate choice: 2X never honoured, 8X only in 3.0
	always_comb begin
		bpc = mode30_r ? BYTES_4X : BYTES_1X;
		if (mode30_r && command_r[1])
			bpc = BYTES_8X;
		else if (!mode30_r && command_r[2])
			bpc = BYTES_4X;
	end

	assign status = {27'h0, lock_r, mode30_r,
		mode30_r ? RATE_CAP_30 : RATE_CAP_20};

	// link clock divider; answers to the card change on the falling phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= '0;
			link.link_clk <= 1'b0;
		end else if (div_r == LINK_HALF_CYC[$bits(div_r)-1:0] - 1'b1) begin
			div_r <= '0;
			link.link_clk <= ~link.link_clk;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end
	assign lfall = link.link_clk &&
		div_r == LINK_HALF_CYC[$bits(div_r)-1:0] - 1'b1;

	// target only: this end answers requests and never starts one
	// no ordering between priority classes, each served on arrival
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= D_IDLE;
			lat_r <= '0;
			is_wr_r <= 1'b0;
			link.ack_pin <= 1'b1;
			link.ok <= 1'b0;
			link.rdata <= '0;
		end else if (!lock_r && link.ack_pin == mode30_r) begin
			link.ack_pin <= ~mode30_r; // idle level tracks mode
		end else if (lfall) begin
			case (st_r)
				D_IDLE: if (req && command_r[CMD_PORT_EN_BIT]) begin
					lat_r <= '0;
					is_wr_r <= kind == K_WRITE;
					if (kind == K_RSVD ||
						(pci66 && path != PATH_FRAME)) begin
						link.ok <= 1'b0;
						link.ack_pin <= mode30_r;
						st_r <= D_HOLD;
					end else if (kind == K_READ || kind == K_WRITE) begin
						st_r <= D_WAIT;
					end else begin
						link.ok <= 1'b1;
						link.ack_pin <= mode30_r;
						st_r <= D_HOLD;
					end
				end
				D_WAIT: begin
					lat_r <= lat_r + 1'b1;
					if (lat_r >= lat_need || lat_r >= lat_lim) begin
						link.ok <= lat_r >= lat_need;
						link.rdata <= mem_r[widx];
						link.ack_pin <= mode30_r;
						st_r <= D_HOLD;
					end
				end
				D_HOLD: if (!req) begin
					link.ack_pin <= ~mode30_r;
					st_r <= D_IDLE;
				end
				default: st_r <= D_IDLE;
			endcase
		end
	end

	// memory written only by accepted writes that met the latency limit
	always_ff @(posedge aclk) begin
		// an answer exactly at the limit is accepted and stored only if lat_need equals it
		if (lfall && st_r == D_WAIT && is_wr_r && lat_r >= lat_need)
			mem_r[widx] <= s2_r[31:0];
	end

	// counters and snoop pulses; no lock or error pins exist
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_cnt_r <= '0;
			rej_cnt_r <= '0;
			snoop_cnt_r <= '0;
			bytes_r <= '0;
			wbuf_snoop <= 1'b0;
			proc_snoop <= 1'b0;
		end else begin
			wbuf_snoop <= 1'b0;
			proc_snoop <= 1'b0;
			if (lfall && st_r == D_IDLE && req &&
				command_r[CMD_PORT_EN_BIT]) begin
				if (kind == K_RSVD || (pci66 && path != PATH_FRAME)) begin
					rej_cnt_r <= rej_cnt_r + 1'b1;
				end else begin
					acc_cnt_r <= acc_cnt_r + 1'b1; // any path
					if (path != PATH_FRAME) begin
						wbuf_snoop <= 1'b1;
						snoop_cnt_r <= snoop_cnt_r + 1'b1;
					end else if (kind == K_READ || kind == K_WRITE) begin
						proc_snoop <= 1'b1;
					end
					if (kind == K_READ || kind == K_WRITE)
						bytes_r <= bytes_r + 32'(bpc) * BLOCK_CLOCKS;
				end
			end
		end
	end

	// axi write side: address and data taken in either order
	assign wr_go = aw_h_r && w_h_r && !s_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h_r <= 1'b0;
			w_h_r <= 1'b0;
			awaddr_r <= '0;
			wdat_r <= '0;
			wstrb_r <= '0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'h0;
		end else begin
			s_awready <= !aw_h_r && !(s_awvalid && s_awready);
			s_wready <= !w_h_r && !(s_wvalid && s_wready);
			if (s_awvalid && s_awready) begin
				aw_h_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_h_r <= 1'b1;
				wdat_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_h_r <= 1'b0;
				w_h_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (awaddr_r == REG_COMMAND ||
					awaddr_r == REG_CONTROL ||
					awaddr_r == REG_FW_DATA) ? 2'h0 : 2'h2;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// writable registers; data rate is taken once then frozen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			command_r <= COMMAND_RST;
			control_r <= CONTROL_RST;
			lock_r <= 1'b0;
		end else if (wr_go && wstrb_r[0]) begin
			if (awaddr_r == REG_COMMAND) begin
				command_r[7:3] <= wdat_r[7:3];
				if (!lock_r) begin
					command_r[2:0] <= wdat_r[2:0];
					lock_r <= 1'b1; // later rate writes dropped
				end
			end
			if (awaddr_r == REG_CONTROL)
				control_r <= wdat_r[7:0];
		end
	end

	// fast write: core pushes a word to the card by toggle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.fw_tgl <= 1'b0;
			link.fw_data <= '0;
		end else if (wr_go && awaddr_r == REG_FW_DATA &&
			command_r[CMD_FW_EN_BIT] && command_r[CMD_PORT_EN_BIT]) begin
			link.fw_tgl <= ~link.fw_tgl; // hub-to-port write
			link.fw_data <= wdat_r;
		end
	end

	// axi read side; unmapped offsets answer slverr with zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= 2'h0;
		end else begin
			s_arready <= !s_rvalid && !(s_arvalid && s_arready);
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp <= 2'h0;
				case (s_araddr)
					REG_STATUS: s_rdata <= status;
					REG_COMMAND: s_rdata <= {24'h0, command_r};
					REG_CONTROL: s_rdata <= {24'h0, control_r};
					REG_ACCEPT_CNT: s_rdata <= acc_cnt_r;
					REG_REJECT_CNT: s_rdata <= rej_cnt_r;
					REG_SNOOP_CNT: s_rdata <= snoop_cnt_r;
					REG_BYTES: s_rdata <= bytes_r;
					default: begin
						s_rdata <= '0;
						s_rresp <= 2'h2;
					end
				endcase
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* atp_link_sva.sv */
// assertions on the link wires between the device end and the card end
// assumes one core clock for both ends and a synchronous active-low reset
`timescale 1ns/1ns
module atp_link_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic link_clk,
	input wire logic req_pin,
	input wire logic [1:0] path,
	input wire logic [3:0] cmd_pin,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack_pin,
	input wire logic ok,
	input wire logic [31:0] rdata,
	input wire logic fw_tgl,
	input wire logic [31:0] fw_data
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// each link clock half lasts two core cycles
	sequence s_stay_high;
		link_clk ##1 !link_clk;
	endsequence
	sequence s_stay_low;
		!link_clk ##1 link_clk;
	endsequence
	// request pin differs from answer pin: a transfer is under way
	sequence s_waiting;
		req_pin != ack_pin;
	endsequence
	sequence s_waiting_held;
		s_waiting ##0 $stable(req_pin);
	endsequence

	a_link_high_two: assert property (
		$rose(link_clk) |=> s_stay_high)
		else $error("link clock high phase is not two cycles");
	a_link_low_two: assert property (
		$fell(link_clk) |=> s_stay_low)
		else $error("link clock low phase is not two cycles");
	// mode-free: every answer move lands on the request level
	a_ack_tracks_req: assert property (
		$changed(ack_pin) |-> ack_pin == req_pin)
		else $error("answer pin moved without a request");
	a_req_held: assert property (
		s_waiting |=> $stable(req_pin))
		else $error("request pin moved before the answer");
	a_payload_held: assert property (
		s_waiting_held |-> $stable(cmd_pin) && $stable(path) &&
		$stable(addr) && $stable(wdata))
		else $error("request payload moved while waiting");
	a_answer_held: assert property (
		$changed(ack_pin) |=> ($stable(ok) && $stable(rdata)) [*2])
		else $error("answer data moved right after the answer");
	a_fw_single_toggle: assert property (
		$changed(fw_tgl) |=> $stable(fw_tgl) [*2])
		else $error("fast write toggle moved twice");
	a_fw_data_held: assert property (
		$changed(fw_tgl) |=> $stable(fw_data) [*3])
		else $error("fast write data moved after its toggle");
endmodule

/* tb_agp_target_port.sv */
// self-checking bench: axi master, card user side and a reference model
// assumes both ends share aclk; the device makes the link clock itself
`timescale 1ns/1ns
module tb_agp_target_port import atp_pkg::*;;
	logic aclk = 0, aresetn = 0, power_good = 0, mode30_detect = 0;
	logic [7:0] s_awaddr = 0, s_araddr = 0;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
	logic s_arvalid = 0, s_rready = 0, cmd_valid = 0;
	logic [31:0] s_wdata = 0, cmd_addr = 0, cmd_wdata = 0;
	logic [3:0] s_wstrb = 0, cmd_code = 0;
	logic [1:0] cmd_path = 0, s_bresp, s_rresp;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic wbuf_snoop, proc_snoop, cmd_ready, resp_valid, resp_ok, fw_valid;
	logic [31:0] s_rdata, resp_rdata, fw_rdata, d;
	logic [31:0] mem[16];
	logic [31:0] fw_q[$];
	logic m30 = 0;
	int n_fail = 0, total_checks = 0, n_wb = 0, n_pc = 0, bytes_x, bpc;
	int n_acc, n_rej, n_snp;

	atp_link_if u_atp_link_if ();
	atp_dev #(.MEM_DEPTH(16)) u_atp_dev (.aclk, .aresetn, .power_good,
		.mode30_detect, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
		.s_rready, .wbuf_snoop, .proc_snoop, .link(u_atp_link_if));
	atp_card u_atp_card (.aclk, .aresetn, .mode30_strap(mode30_detect),
		.cmd_valid, .cmd_ready, .cmd_code, .cmd_path, .cmd_addr,
		.cmd_wdata, .resp_valid, .resp_ok, .resp_rdata, .fw_valid,
		.fw_rdata, .link(u_atp_link_if));
	atp_link_sva u_atp_link_sva (.aclk, .aresetn,
		.link_clk(u_atp_link_if.link_clk), .req_pin(u_atp_link_if.req_pin),
		.path(u_atp_link_if.path), .cmd_pin(u_atp_link_if.cmd_pin),
		.addr(u_atp_link_if.addr), .wdata(u_atp_link_if.wdata),
		.ack_pin(u_atp_link_if.ack_pin), .ok(u_atp_link_if.ok),
		.rdata(u_atp_link_if.rdata), .fw_tgl(u_atp_link_if.fw_tgl),
		.fw_data(u_atp_link_if.fw_data));

	always #2 aclk = ~aclk;
	// pulse counters and fast write capture, pulses last one cycle
	always @(posedge aclk) begin
		n_wb <= n_wb + wbuf_snoop;
		n_pc <= n_pc + proc_snoop;
		if (fw_valid) fw_q.push_back(fw_rdata);
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic hang();
		n_fail++;
		$display("[ERR] %0t wait ran out", $time);
		complete_run();
	endtask
	// axi write: address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		if (i == 100) hang();
		chk({30'h0, s_bresp}, {30'h0, er}, "write resp");
		s_bready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		if (i == 100) hang();
		chk(s_rdata, e, "read data");
		chk({30'h0, s_rresp}, {30'h0, er}, "read resp");
		s_rready <= 1'b0;
	endtask
	// reference decode: 0 read, 1 write, 2 flush or fence, 3 refused
	function automatic int kind(input logic m, input logic [3:0] c);
		case (c)
			4'h0: return 0;
			4'h1, 4'h8, 4'h9: return m ? 3 : 0;
			4'h4: return 1;
			4'h5: return m ? 3 : 1;
			4'ha, 4'hc: return 2;
			default: return 3;
		endcase
	endfunction
	// one card request, judged against the memory model
	task automatic op(input logic [3:0] c, input logic [1:0] p,
		input logic [31:0] a, input logic [31:0] v, input bit acc);
		int i, k, wb0, pc0;
		bit fwd;
		k = acc ? kind(m30, c) : 3;
		// card refuses the unsupported 3.0 codes before the link
		fwd = !(m30 && (c == 4'h3 || c == 4'h6 || c == 4'h7 ||
			c == 4'he));
		wb0 = n_wb;
		pc0 = n_pc;
		@(posedge aclk);
		cmd_code <= c;
		cmd_path <= p;
		cmd_addr <= a;
		cmd_wdata <= v;
		cmd_valid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (cmd_ready) break;
		end
		if (i == 100) hang();
		cmd_valid <= 1'b0;
		for (i = 0; i < 3000; i++) begin
			@(posedge aclk);
			if (resp_valid) break;
		end
		if (i == 3000) hang();
		chk({31'h0, resp_ok}, {31'h0, k != 3}, "resp ok");
		if (k == 0) chk(resp_rdata, mem[a[3:0]], "mem read");
		if (k == 1) mem[a[3:0]] = v;
		if (fwd && kind(m30, c) == 3) n_rej++;
		if (fwd && kind(m30, c) != 3) n_acc++;
		if (fwd && kind(m30, c) != 3 && p != PATH_FRAME) n_snp++;
		if (k < 2) begin
			bytes_x += bpc * 4;
			chk(n_wb - wb0, p != PATH_FRAME, "wbuf snoop");
			chk(n_pc - pc0, p == PATH_FRAME, "proc snoop");
		end
	endtask
	// reset, latch the mode strap, then set the rate and check a second rate write is dropped
	task automatic start(input logic m, input logic [2:0] rate);
		@(posedge aclk);
		aresetn <= 1'b0;
		mode30_detect <= m;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		power_good <= 1'b1;
		repeat (4) @(posedge aclk);
		power_good <= 1'b0;
		m30 = m;
		bytes_x = 0;
		n_acc = 0;
		n_rej = 0;
		n_snp = 0;
		bpc = (m && rate[1]) ? 32 : ((m || rate[2]) ? 16 : 4);
		rd_chk(REG_STATUS, {28'h0, m, m ? RATE_CAP_30 : RATE_CAP_20},
			2'h0);
		chk({30'h0, u_atp_link_if.req_pin, u_atp_link_if.ack_pin},
			{30'h0, ~m, ~m}, "idle levels");
		axi_wr(REG_COMMAND, {26'h0, 3'h6, rate}, 2'h0);
		axi_wr(REG_COMMAND, {26'h0, 3'h6, ~rate}, 2'h0);
		rd_chk(REG_COMMAND, {26'h0, 3'h6, rate}, 2'h0);
		rd_chk(REG_STATUS, {28'h1, m, m ? RATE_CAP_30 : RATE_CAP_20},
			2'h0);
	endtask

	// main sequence: both modes, pci66 limits, fast write, bad addresses
	initial begin
		int i;
		void'($urandom(32'hd252e4bd));
		for (int mi = 0; mi < 2; mi++) begin
			start(mi[0], mi[0] ? 3'h2 : 3'h4);
			for (i = 0; i < 16; i++)
				op(4'h4, PATH_SBA, i, $urandom, 1'b1);
			for (i = 0; i < 16; i++)
				op(i[3:0], 2'($urandom_range(2)), $urandom, $urandom,
					1'b1);
			for (i = 0; i < 16; i++)
				op(4'h0, PATH_PIPE, i, 32'h0, 1'b1);
			rd_chk(REG_BYTES, bytes_x, 2'h0);
			rd_chk(REG_ACCEPT_CNT, n_acc, 2'h0);
			rd_chk(REG_REJECT_CNT, n_rej, 2'h0);
			rd_chk(REG_SNOOP_CNT, n_snp, 2'h0);
		end
		axi_wr(REG_CONTROL, 32'h90, 2'h0);
		op(4'h4, PATH_FRAME, 32'h3, 32'h55, 1'b0);
		axi_wr(REG_CONTROL, 32'h91, 2'h0);
		op(4'h4, PATH_PIPE, 32'h3, 32'h66, 1'b0);
		op(4'h4, PATH_FRAME, 32'h3, 32'h77, 1'b1);
		op(4'h0, PATH_FRAME, 32'h3, 32'h0, 1'b1);
		rd_chk(REG_CONTROL, 32'h91, 2'h0);
		d = $urandom;
		fw_q.delete();
		axi_wr(REG_FW_DATA, d, 2'h0);
		for (i = 0; i < 200 && fw_q.size() == 0; i++) @(posedge aclk);
		if (fw_q.size() == 0) hang();
		// a stray second word would arrive within these cycles
		repeat (8) @(posedge aclk);
		chk(fw_q.size(), 1, "fast write count");
		if (fw_q.size() > 0) chk(fw_q[0], d, "fast write data");
		rd_chk(8'h20, 32'h0, 2'h2);
		rd_chk(REG_FW_DATA, 32'h0, 2'h2);
		axi_wr(REG_STATUS, 32'hff, 2'h2);
		complete_run();
	end
endmodule
